// file: hcso_bench.sv
// self-checking bench of the commutation block
`timescale 1ns/10ps
`default_nettype none
`include "hcso_regs.svh"
module hcso_bench;
  import hcso_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [2:0] hall_cmd = 3'h4;
  logic sto_a_cmd = 1'b1;
  logic sto_b_cmd = 1'b1;
  logic enc_stp = 1'b0;
  wire awready, wready, bvalid, arready, rvalid, bridge_en, led_g, led_r, irq;
  wire sto_a, sto_b, enc_a, enc_b;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [2:0] hall, ph_hi, ph_lo;
  wire hcso_cur_t cur_a, cur_b, cur_c;
  int bad_count = 0;
  int checks = 0;
  // hall code, phasing and expected {high mask, low mask}
  logic [9:0] rows [16] = '{10'h20A, 10'h262, 10'h280, 10'h2E1, 10'h30C, 10'h340, 10'h394,
    10'h3D1, 10'h000, 10'h062, 10'h091, 10'h0E1, 10'h10C, 10'h14A, 10'h194, 10'h1C0};
  logic [2:0] seq [6] = '{3'h6, 3'h2, 3'h3, 3'h1, 3'h5, 3'h4};

  hcso_top u_dut (
    .CLK(clk), .RESET(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .HALL_IN(hall), .SAFE_OFF_IN_A(sto_a), .SAFE_OFF_IN_B(sto_b), .ENC_A(enc_a),
    .ENC_B(enc_b), .PHASE_HI(ph_hi), .PHASE_LO(ph_lo), .CUR_A(cur_a), .CUR_B(cur_b),
    .CUR_C(cur_c), .BRIDGE_EN(bridge_en), .LED_GREEN(led_g), .LED_RED(led_r), .IRQ(irq)
  );
  hcso_motor u_motor (
    .clk(clk), .hall_cmd(hall_cmd), .sto_a_cmd(sto_a_cmd), .sto_b_cmd(sto_b_cmd),
    .enc_stp(enc_stp), .hall(hall), .sto_a(sto_a), .sto_b(sto_b), .enc_a(enc_a), .enc_b(enc_b)
  );

  // ==========
  // clock, checks and bus tasks
  initial begin
    forever #4 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic off_chk;
    chk("drive", 32'h0, {ph_hi, ph_lo});
    chk("bridge", 32'h0, bridge_en);
    chk("led_red", 32'h1, led_r);
    chk("led_green", 32'h0, led_g);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic pa;
    logic pw;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    while (pa || pw) begin
      @(posedge clk);
      if (pa && awready === 1'b1) begin
        pa = 1'b0;
        awvalid <= 1'b0;
      end
      if (pw && wready === 1'b1) begin
        pw = 1'b0;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", er, bresp);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m,
                    input logic [1:0] er);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk("rdata", exp, rdata & m);
    chk("rresp", er, rresp);
  endtask

  task automatic rst_run;
    rst <= 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    settle(1);
  endtask

  task automatic results;
    if (bad_count == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge clk);
    bad_count++;
    results();
  end

  // ==========
  // main sequence
  initial begin
    logic [9:0] r;
    logic signed [9:0] s;
    hcso_cur_t ca [64];
    logic nz;
    nz = 1'b0;
    rst_run();
    off_chk();
    chk("irq", 32'h0, irq);
    for (int i = 0; i < 16; i++) begin
      r = rows[i];
      wr(`HCSO_A_CTRL, {29'h0, r[9], 2'h1}, `HCSO_RESP_OK);
      hall_cmd <= r[8:6];
      settle(6);
      chk("drive", {26'h0, r[5:0]}, {ph_hi, ph_lo});
      chk("cur_a", 32'h0, cur_a);
      chk("led_green", 32'h1, led_g);
    end
    // safe-off trip, interrupt raise, clear and mask
    wr(`HCSO_A_CTRL, 32'h1, `HCSO_RESP_OK);
    hall_cmd <= 3'h4;
    repeat (6) @(posedge clk);
    wr(`HCSO_A_ISTAT, 32'h7, `HCSO_RESP_OK);
    wr(`HCSO_A_IMASK, 32'h1, `HCSO_RESP_OK);
    sto_a_cmd <= 1'b0;
    settle(4);
    off_chk();
    settle(2);
    chk("irq", 32'h1, irq);
    rd(`HCSO_A_ISTAT, 32'h1, 32'h1, `HCSO_RESP_OK);
    wr(`HCSO_A_ISTAT, 32'h1, `HCSO_RESP_OK);
    chk("irq", 32'h0, irq);
    sto_a_cmd <= 1'b1;
    settle(6);
    chk("drive", 32'h0C, {ph_hi, ph_lo});
    @(posedge clk);
    sto_b_cmd <= 1'b0;
    settle(4);
    off_chk();
    wr(`HCSO_A_IMASK, 32'h0, `HCSO_RESP_OK);
    rd(`HCSO_A_ISTAT, 32'h1, 32'h1, `HCSO_RESP_OK);
    chk("irq", 32'h0, irq);
    sto_b_cmd <= 1'b1;
    // table rewrite, read back, unmapped place
    wr({2'h1, 1'h0, 3'h4, 2'h0}, 32'h11, `HCSO_RESP_OK);
    settle(6);
    chk("drive", 32'h11, {ph_hi, ph_lo});
    rd({2'h1, 1'h0, 3'h4, 2'h0}, 32'h11, 32'h3F, `HCSO_RESP_OK);
    rd(8'h30, 32'h0, 32'hFFFFFFFF, `HCSO_RESP_ERR);
    wr(8'h30, 32'h5, `HCSO_RESP_ERR);
    // sine mode from the encoder
    wr(`HCSO_A_CTRL, 32'h3, `HCSO_RESP_OK);
    for (int k = 0; k < 64; k++) begin
      @(posedge clk);
      enc_stp <= 1'b1;
      @(posedge clk);
      enc_stp <= 1'b0;
      settle(10);
      ca[k] = cur_a;
      s = cur_a + cur_b + cur_c;
      nz = nz | (cur_a != 8'h00);
      chk("cur_sum", 32'h0, {{22{s[9]}}, s});
      chk("drive", 32'h0, {ph_hi, ph_lo});
      if (k >= 16) begin
        chk("cur_lag", ca[k - 16], cur_b);
      end
    end
    chk("cur_live", 32'h1, nz);
    // second reset, defaults back, revolution count
    @(posedge clk);
    hall_cmd <= 3'h4;
    rst_run();
    off_chk();
    rd(`HCSO_A_CTRL, 32'h0, 32'hFFFFFFFF, `HCSO_RESP_OK);
    rd(`HCSO_A_POLES, 32'h8, 32'hFF, `HCSO_RESP_OK);
    rd(`HCSO_A_ESTEP, 32'h1, 32'hFFFF, `HCSO_RESP_OK);
    rd(`HCSO_A_IMASK, 32'h0, 32'hFFFFFFFF, `HCSO_RESP_OK);
    wr(`HCSO_A_CTRL, 32'h1, `HCSO_RESP_OK);
    settle(6);
    chk("drive", 32'h0C, {ph_hi, ph_lo});
    wr(`HCSO_A_POLES, 32'h4, `HCSO_RESP_OK);
    for (int i = 0; i < 12; i++) begin
      hall_cmd <= seq[i % 6];
      repeat (6) @(posedge clk);
      if (i == 5) begin
        rd(`HCSO_A_REVS, 32'h0, 32'hFFFF, `HCSO_RESP_OK);
      end
    end
    rd(`HCSO_A_REVS, 32'h1, 32'hFFFF, `HCSO_RESP_OK);
    rd(`HCSO_A_ISTAT, 32'h4, 32'h6, `HCSO_RESP_OK);
    results();
  end
endmodule
`default_nettype wire

// file: hcso_ctab.sv
// reprogrammable hall to phase table with registered reads
`timescale 1ns/10ps
`default_nettype none
`include "hcso_regs.svh"
module hcso_ctab (
  input wire logic clk,
  input wire logic rst,
  hcso_tab_if.mem tab
);
  import hcso_pkg::*;
  localparam logic [95:0] DEF = {`HCSO_TAB60_DEF, `HCSO_TAB120_DEF};
  hcso_drv_t ent_q [16];

  // ==========================================
  // table store
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < 16; i++) begin
        ent_q[i] <= DEF[6*i +: 6]; // RULE_07 RULE_08
      end
    end else if (tab.wr_en) begin
      ent_q[tab.wr_idx] <= tab.wr_data; // RULE_10
    end
  end

  // ==========================================
  // read ports
  always_ff @(posedge clk) begin
    tab.sw_data <= ent_q[tab.sw_idx];
    tab.hw_data <= ent_q[tab.hw_idx];
  end

  deflt_load_a: assert property (@(posedge clk) rst |=> ent_q[4] == DEF[24 +: 6] && ent_q[12] == DEF[72 +: 6]) // RULE_10
    else $error("table not loaded with defaults");
endmodule
`default_nettype wire

// file: hcso_motor.sv
// motor side model: hall sensors, safe-off switches and quadrature encoder
`timescale 1ns/10ps
`default_nettype none
module hcso_motor (
  input wire logic clk,
  input wire logic [2:0] hall_cmd,
  input wire logic sto_a_cmd,
  input wire logic sto_b_cmd,
  input wire logic enc_stp,
  output logic [2:0] hall,
  output logic sto_a,
  output logic sto_b,
  output logic enc_a,
  output logic enc_b
);
  logic [1:0] pos_q = 2'h0;
  // ==========
  // encoder, one line changes per count, a leads b going forward
  always_ff @(posedge clk) begin
    if (enc_stp) begin
      pos_q <= pos_q + 2'h1;
    end
  end
  assign enc_a = pos_q[1] ^ pos_q[0];
  assign enc_b = pos_q[1];
  // ==========
  // hall and safe-off switches follow the bench
  assign hall = hall_cmd;
  assign sto_a = sto_a_cmd;
  assign sto_b = sto_b_cmd;
endmodule
`default_nettype wire

// file: hcso_pkg.sv
// types shared by the commutation block
package hcso_pkg;
  typedef enum logic [1:0] {
    RD_IDLE = 2'b00,
    RD_WAIT = 2'b01,
    RD_RESP = 2'b10
  } hcso_rd_e;
  typedef logic [5:0] hcso_drv_t;
  typedef logic signed [7:0] hcso_cur_t;
endpackage

// file: hcso_regs.svh
// register map, field positions and reset values of the commutation block
`ifndef HCSO_REGS_SVH
`define HCSO_REGS_SVH
`define HCSO_A_CTRL 8'h00
`define HCSO_A_STAT 8'h04
`define HCSO_A_ISTAT 8'h08
`define HCSO_A_IMASK 8'h0C
`define HCSO_A_POLES 8'h10
`define HCSO_A_ESTEP 8'h14
`define HCSO_A_REVS 8'h18
`define HCSO_TAB_PAGE 2'h1
`define HCSO_B_EN 0
`define HCSO_B_SINE 1
`define HCSO_B_PH60 2
`define HCSO_I_TRIP 0
`define HCSO_I_BAD 1
`define HCSO_I_STEP 2
`define HCSO_CTRL_RST 3'h0
`define HCSO_IRQ_RST 3'h0
`define HCSO_POLES_RST 8'h08
`define HCSO_ESTEP_RST 16'h0001
`define HCSO_LAST_STEP 3'h5
`define HCSO_SIN_STEPS 6'h30
`define HCSO_SIN_THIRD 6'h10
`define HCSO_RESP_OK 2'h0
`define HCSO_RESP_ERR 2'h2
`define HCSO_TAB60_DEF {6'h11, 6'h14, 6'h00, 6'h0C, 6'h21, 6'h00, 6'h22, 6'h0A}
`define HCSO_TAB120_DEF {6'h00, 6'h14, 6'h0A, 6'h0C, 6'h21, 6'h11, 6'h22, 6'h00}
`endif

// file: hcso_tab_if.sv
// carrier between the block and its commutation table
`timescale 1ns/10ps
`default_nettype none
interface hcso_tab_if;
  logic wr_en;
  logic [3:0] wr_idx;
  logic [3:0] sw_idx;
  logic [3:0] hw_idx;
  hcso_pkg::hcso_drv_t wr_data;
  hcso_pkg::hcso_drv_t sw_data;
  hcso_pkg::hcso_drv_t hw_data;
  modport ctl (output wr_en, wr_idx, wr_data, sw_idx, hw_idx, input sw_data, hw_data);
  modport mem (input wr_en, wr_idx, wr_data, sw_idx, hw_idx, output sw_data, hw_data);
endinterface
`default_nettype wire

// file: hcso_top.sv
// hall commutation with safe-off gating, sine mode and register bus
//
// Design decisions made here: the address map and the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
`include "hcso_regs.svh"
// Function
// RULE_01 - phases may carry torque only while both safe-off inputs are high.
// RULE_02 - the status light is green while the bridge is enabled and red otherwise.
// RULE_03 - sine mode runs from the encoder and trapezoid mode from the hall lines.
// RULE_04 - sine mode gives three current commands 120 degrees apart summing to zero.
// RULE_05 - trapezoid mode drives exactly one phase high and one low, the third idle.
// RULE_06 - a setting picks 120 or 60 degree hall phasing and decoding follows it.
// RULE_07 - 60 degree default codes 100,110,111,011,001,000 give AC, BC, BA, CA, CB, AB.
// RULE_08 - 120 degree default codes 100,110,010,011,001,101 give AC, BC, BA, CA, CB, AB.
// RULE_09 - codes 101 and 010 at 60 degrees, 111 and 000 at 120 degrees drive nothing.
// RULE_10 - the hall to phase table is writable and loaded with defaults at reset.
// RULE_11 - electrical cycles per revolution equal the pole count divided by two.
// RULE_12 - inputs are synchronised and drive drops one cycle after safe-off falls.
module hcso_top (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [2:0] HALL_IN,
  input wire logic SAFE_OFF_IN_A,
  input wire logic SAFE_OFF_IN_B,
  input wire logic ENC_A,
  input wire logic ENC_B,
  output logic [2:0] PHASE_HI,
  output logic [2:0] PHASE_LO,
  output hcso_pkg::hcso_cur_t CUR_A,
  output hcso_pkg::hcso_cur_t CUR_B,
  output hcso_pkg::hcso_cur_t CUR_C,
  output logic BRIDGE_EN,
  output logic LED_GREEN,
  output logic LED_RED,
  output logic IRQ
);
  import hcso_pkg::*;
  localparam logic [5:0] Q1 = 6'(`HCSO_SIN_STEPS / 6'h04);
  localparam logic [5:0] Q2 = Q1 + Q1;
  localparam logic [5:0] Q3 = Q2 + Q1;
  localparam logic [7:0] QW [13] = '{8'h00, 8'h10, 8'h1F, 8'h2E, 8'h3C, 8'h49, 8'h55,
                                     8'h5F, 8'h68, 8'h6F, 8'h74, 8'h77, 8'h78};

  hcso_tab_if tab();
  hcso_ctab u_tab (.clk(CLK), .rst(RESET), .tab(tab));

  function automatic logic hall_bad(input logic ph60, input logic [2:0] h);
    hall_bad = ph60 ? (h == 3'b101 || h == 3'b010) : (h == 3'b111 || h == 3'b000); // RULE_09
  endfunction

  function automatic logic drv_ok(input hcso_drv_t e);
    drv_ok = $onehot(e[5:3]) && $onehot(e[2:0]) && ((e[5:3] & e[2:0]) == 3'h0); // RULE_05
  endfunction

  function automatic hcso_cur_t sin48(input logic [5:0] i);
    logic [5:0] k;
    logic [7:0] m;
    if (i < Q1) k = i;
    else if (i < Q2) k = 6'(Q2 - i);
    else if (i < Q3) k = 6'(i - Q2);
    else k = 6'(`HCSO_SIN_STEPS - i);
    m = QW[k[3:0]];
    sin48 = (i < Q2) ? hcso_cur_t'(m) : hcso_cur_t'(8'h00 - m);
  endfunction

  // ==========================================
  // input synchronisers
  logic [6:0] sy1_q, sy2_q;
  always_ff @(posedge CLK) begin
    if (RESET) begin
      sy1_q <= 7'h00;
      sy2_q <= 7'h00;
    end else begin
      sy1_q <= {HALL_IN, SAFE_OFF_IN_A, SAFE_OFF_IN_B, ENC_A, ENC_B}; // RULE_12
      sy2_q <= sy1_q;
    end
  end
  logic [2:0] hall;
  logic so_ok;
  logic [1:0] enc;
  assign hall = sy2_q[6:4];
  assign so_ok = sy2_q[3] & sy2_q[2]; // RULE_01
  assign enc = sy2_q[1:0];

  // ==========================================
  // control registers and bridge state
  logic [2:0] ctrl_q, istat_q, imask_q, ev;
  logic [7:0] poles_q;
  logic [15:0] estep_q, rev_q;
  logic bridge_d, bridge_q, sine, ph60;
  assign sine = ctrl_q[`HCSO_B_SINE];
  assign ph60 = ctrl_q[`HCSO_B_PH60];
  assign bridge_d = ctrl_q[`HCSO_B_EN] & so_ok; // RULE_01
  always_ff @(posedge CLK) begin
    if (RESET) bridge_q <= 1'b0;
    else bridge_q <= bridge_d;
  end
  assign BRIDGE_EN = bridge_q;
  assign LED_GREEN = bridge_q; // RULE_02
  assign LED_RED = ~bridge_q; // RULE_02

  // ==========================================
  // trapezoid decode
  logic bad_p_q, so_p_q;
  logic [2:0] hall_p_q;
  assign tab.hw_idx = {ph60, hall}; // RULE_06
  always_ff @(posedge CLK) begin
    if (RESET) begin
      bad_p_q <= 1'b1;
      hall_p_q <= 3'h0;
      so_p_q <= 1'b0;
    end else begin
      bad_p_q <= hall_bad(ph60, hall); // RULE_09
      hall_p_q <= hall;
      so_p_q <= so_ok;
    end
  end
  always_ff @(posedge CLK) begin
    if (RESET || !bridge_d || sine || bad_p_q || !drv_ok(tab.hw_data)) begin // RULE_03 RULE_12
      PHASE_HI <= 3'h0;
      PHASE_LO <= 3'h0;
    end else begin
      PHASE_HI <= tab.hw_data[5:3]; // RULE_05
      PHASE_LO <= tab.hw_data[2:0];
    end
  end
  logic hall_chg;
  assign hall_chg = (hall != hall_p_q) && !hall_bad(ph60, hall) && !hall_bad(ph60, hall_p_q);
  assign ev[`HCSO_I_TRIP] = so_p_q & ~so_ok & ctrl_q[`HCSO_B_EN];
  assign ev[`HCSO_I_BAD] = hall_bad(ph60, hall) & ~hall_bad(ph60, hall_p_q);
  assign ev[`HCSO_I_STEP] = hall_chg & ~sine;

  // ==========================================
  // encoder angle and sine currents
  logic [1:0] enc_p_q;
  logic [15:0] pre_q, estep_m1;
  logic [5:0] ang_q, ang_b;
  logic mv, fwd, ang_wrap;
  assign mv = ^(enc ^ enc_p_q);
  assign fwd = enc[1] ^ enc_p_q[0];
  assign estep_m1 = (estep_q == 16'h0000) ? 16'h0000 : 16'(estep_q - 16'h0001);
  assign ang_wrap = mv && (fwd ? (pre_q >= estep_m1 && ang_q == 6'(`HCSO_SIN_STEPS - 6'h01))
                               : (pre_q == 16'h0000 && ang_q == 6'h00));
  always_ff @(posedge CLK) begin
    if (RESET) begin
      enc_p_q <= 2'h0;
      pre_q <= 16'h0000;
      ang_q <= 6'h00;
    end else begin
      enc_p_q <= enc; // RULE_03
      if (mv && fwd) begin
        if (pre_q >= estep_m1) begin
          pre_q <= 16'h0000;
          ang_q <= (ang_q == 6'(`HCSO_SIN_STEPS - 6'h01)) ? 6'h00 : 6'(ang_q + 6'h01);
        end else begin
          pre_q <= 16'(pre_q + 16'h0001);
        end
      end else if (mv) begin
        if (pre_q == 16'h0000) begin
          pre_q <= estep_m1;
          ang_q <= (ang_q == 6'h00) ? 6'(`HCSO_SIN_STEPS - 6'h01) : 6'(ang_q - 6'h01);
        end else begin
          pre_q <= 16'(pre_q - 16'h0001);
        end
      end
    end
  end
  assign ang_b = (ang_q >= `HCSO_SIN_THIRD) ? 6'(ang_q - `HCSO_SIN_THIRD)
                                            : 6'(ang_q + `HCSO_SIN_STEPS - `HCSO_SIN_THIRD);
  hcso_cur_t ia, ib;
  assign ia = sin48(ang_q);
  assign ib = sin48(ang_b); // RULE_04
  always_ff @(posedge CLK) begin
    if (RESET || !bridge_d || !sine) begin // RULE_01 RULE_03
      CUR_A <= 8'sh00;
      CUR_B <= 8'sh00;
      CUR_C <= 8'sh00;
    end else begin
      CUR_A <= ia;
      CUR_B <= ib;
      CUR_C <= hcso_cur_t'(8'h00 - ia - ib); // RULE_04
    end
  end

  // ==========================================
  // electrical cycles to revolutions
  logic [2:0] step_q;
  logic [6:0] ecyc_q, pairs_m1;
  logic ecyc_tick;
  assign pairs_m1 = (poles_q[7:1] == 7'h00) ? 7'h00 : 7'(poles_q[7:1] - 7'h01); // RULE_11
  assign ecyc_tick = sine ? ang_wrap : (hall_chg && step_q == `HCSO_LAST_STEP);
  always_ff @(posedge CLK) begin
    if (RESET) begin
      step_q <= 3'h0;
      ecyc_q <= 7'h00;
      rev_q <= 16'h0000;
    end else begin
      if (!sine && hall_chg) step_q <= (step_q == `HCSO_LAST_STEP) ? 3'h0 : 3'(step_q + 3'h1);
      if (ecyc_tick) begin
        if (ecyc_q >= pairs_m1) begin
          ecyc_q <= 7'h00;
          rev_q <= 16'(rev_q + 16'h0001); // RULE_11
        end else begin
          ecyc_q <= 7'(ecyc_q + 7'h01);
        end
      end
    end
  end

  // ==========================================
  // bus write side
  logic aw_have_q, w_have_q, do_wr, wr_map;
  logic [7:0] aw_q;
  logic [31:0] wd_q, bm;
  logic [3:0] ws_q;
  assign S_AXI_AWREADY = ~aw_have_q & ~S_AXI_BVALID;
  assign S_AXI_WREADY = ~w_have_q & ~S_AXI_BVALID;
  assign do_wr = aw_have_q & w_have_q & ~S_AXI_BVALID;
  assign bm = {{8{ws_q[3]}}, {8{ws_q[2]}}, {8{ws_q[1]}}, {8{ws_q[0]}}};
  assign wr_map = (aw_q[7:6] == `HCSO_TAB_PAGE) || aw_q == `HCSO_A_CTRL ||
                  aw_q == `HCSO_A_STAT || aw_q == `HCSO_A_ISTAT || aw_q == `HCSO_A_IMASK ||
                  aw_q == `HCSO_A_POLES || aw_q == `HCSO_A_ESTEP || aw_q == `HCSO_A_REVS;
  always_ff @(posedge CLK) begin
    if (RESET) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_q <= 8'h00;
      wd_q <= 32'h0000_0000;
      ws_q <= 4'h0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= `HCSO_RESP_OK;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_have_q <= 1'b1;
        aw_q <= {S_AXI_AWADDR[7:2], 2'b00};
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_have_q <= 1'b1;
        wd_q <= S_AXI_WDATA;
        ws_q <= S_AXI_WSTRB;
      end
      if (do_wr) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= wr_map ? `HCSO_RESP_OK : `HCSO_RESP_ERR;
      end else if (S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end
  assign tab.wr_en = do_wr && aw_q[7:6] == `HCSO_TAB_PAGE && ws_q[0]; // RULE_10
  assign tab.wr_idx = aw_q[5:2];
  assign tab.wr_data = wd_q[5:0];
  always_ff @(posedge CLK) begin
    if (RESET) begin
      ctrl_q <= `HCSO_CTRL_RST;
      imask_q <= `HCSO_IRQ_RST;
      poles_q <= `HCSO_POLES_RST;
      estep_q <= `HCSO_ESTEP_RST;
    end else if (do_wr) begin
      if (aw_q == `HCSO_A_CTRL) ctrl_q <= (ctrl_q & ~bm[2:0]) | (wd_q[2:0] & bm[2:0]); // RULE_06
      if (aw_q == `HCSO_A_IMASK) imask_q <= (imask_q & ~bm[2:0]) | (wd_q[2:0] & bm[2:0]);
      if (aw_q == `HCSO_A_POLES) poles_q <= (poles_q & ~bm[7:0]) | (wd_q[7:0] & bm[7:0]);
      if (aw_q == `HCSO_A_ESTEP) estep_q <= (estep_q & ~bm[15:0]) | (wd_q[15:0] & bm[15:0]);
    end
  end
  logic [2:0] iclr;
  assign iclr = (do_wr && aw_q == `HCSO_A_ISTAT) ? (wd_q[2:0] & bm[2:0]) : 3'h0;
  always_ff @(posedge CLK) begin
    if (RESET) istat_q <= `HCSO_IRQ_RST;
    else istat_q <= (istat_q & ~iclr) | ev;
  end
  assign IRQ = |(istat_q & imask_q);

  // ==========================================
  // bus read side
  hcso_rd_e rd_st_q;
  logic [7:0] ar_q;
  logic [31:0] rmux;
  logic rmap;
  assign S_AXI_ARREADY = (rd_st_q == RD_IDLE);
  assign tab.sw_idx = S_AXI_ARREADY ? S_AXI_ARADDR[5:2] : ar_q[5:2];
  always_comb begin
    rmap = 1'b1;
    rmux = 32'h0000_0000;
    if (ar_q[7:6] == `HCSO_TAB_PAGE) rmux = {26'h0, tab.sw_data};
    else if (ar_q == `HCSO_A_CTRL) rmux = {29'h0, ctrl_q};
    else if (ar_q == `HCSO_A_STAT) rmux = {25'h0, bad_p_q, sine, hall, so_ok, bridge_q};
    else if (ar_q == `HCSO_A_ISTAT) rmux = {29'h0, istat_q};
    else if (ar_q == `HCSO_A_IMASK) rmux = {29'h0, imask_q};
    else if (ar_q == `HCSO_A_POLES) rmux = {24'h0, poles_q};
    else if (ar_q == `HCSO_A_ESTEP) rmux = {16'h0, estep_q};
    else if (ar_q == `HCSO_A_REVS) rmux = {16'h0, rev_q};
    else rmap = 1'b0;
  end
  always_ff @(posedge CLK) begin
    if (RESET) begin
      rd_st_q <= RD_IDLE;
      ar_q <= 8'h00;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= `HCSO_RESP_OK;
    end else begin
      unique case (rd_st_q)
        RD_IDLE: begin
          if (S_AXI_ARVALID) begin
            ar_q <= {S_AXI_ARADDR[7:2], 2'b00};
            rd_st_q <= RD_WAIT;
          end
        end
        RD_WAIT: begin
          S_AXI_RDATA <= rmux;
          S_AXI_RRESP <= rmap ? `HCSO_RESP_OK : `HCSO_RESP_ERR;
          rd_st_q <= RD_RESP;
        end
        RD_RESP: begin
          if (S_AXI_RREADY) rd_st_q <= RD_IDLE;
        end
        default: rd_st_q <= RD_IDLE;
      endcase
    end
  end
  assign S_AXI_RVALID = (rd_st_q == RD_RESP);

  // ==========================================
  // checks
  stoff_cut_a: assert property (@(posedge CLK) disable iff (RESET) // RULE_01
    !so_ok |=> PHASE_HI == 3'h0 && PHASE_LO == 3'h0 && CUR_A == 8'sh00 && !BRIDGE_EN)
    else $error("drive present without safe-off");
  led_state_a: assert property (@(posedge CLK) disable iff (RESET) // RULE_02
    $rose(bridge_d) |=> LED_GREEN && !LED_RED ##0 $rose(BRIDGE_EN))
    else $error("status light wrong on enable");
  mode_excl_a: assert property (@(posedge CLK) disable iff (RESET) // RULE_03
    sine [*2] |=> PHASE_HI == 3'h0 && PHASE_LO == 3'h0)
    else $error("trapezoid drive in sine mode");
  sine_sum_a: assert property (@(posedge CLK) disable iff (RESET) // RULE_04
    9'(CUR_A + CUR_B + CUR_C) == 9'h000 && (sine || $past(sine) || CUR_B == 8'sh00))
    else $error("phase currents do not sum to zero");
  trap_two_a: assert property (@(posedge CLK) disable iff (RESET) // RULE_05
    PHASE_HI != 3'h0 |-> $onehot(PHASE_HI) && $onehot(PHASE_LO) && (PHASE_HI & PHASE_LO) == 3'h0)
    else $error("trapezoid drive not one high one low");
  bad_hall_a: assert property (@(posedge CLK) disable iff (RESET) // RULE_09
    (hall_bad(ph60, hall) && !sine) ##1 1'b1 |=> PHASE_HI == 3'h0 && PHASE_LO == 3'h0)
    else $error("invalid hall code drove a phase");
  dflt_map_a: assert property (@(posedge CLK) disable iff (RESET) // RULE_06
    bridge_d && !sine && hall == 3'b010 && $stable(hall) && $stable(ph60) |=>
      (PHASE_HI != 3'h0) == !ph60)
    else $error("phasing decode mismatch");
  safe_fall_a: assert property (@(posedge CLK) disable iff (RESET) // RULE_12
    $fell(so_ok) |=> !BRIDGE_EN && PHASE_HI == 3'h0 ##1 istat_q[`HCSO_I_TRIP] || !$past(ctrl_q[0], 2))
    else $error("drive not removed after safe-off fall");
  rev_count_a: assert property (@(posedge CLK) disable iff (RESET) // RULE_11
    ecyc_tick && ecyc_q >= pairs_m1 |=> rev_q == 16'($past(rev_q) + 16'h0001) && ecyc_q == 7'h00)
    else $error("revolution count off");
endmodule
`default_nettype wire
